// file: logic/fsov_pkg.sv
// shared constants and types for the volatile status-one register block
`default_nettype none
package fsov_pkg;

  // command codes
  localparam logic [7:0] CMD_READ_STATUS_ONE  = 8'h05;
  localparam logic [7:0] CMD_READ_STATUS_TWO  = 8'h07;
  localparam logic [7:0] CMD_READ_ANY_REG     = 8'h65;
  localparam logic [7:0] CMD_WRITE_REGISTERS  = 8'h01;
  localparam logic [7:0] CMD_WRITE_ANY_REG    = 8'h71;
  localparam logic [7:0] CMD_WRITE_ENABLE     = 8'h06;
  localparam logic [7:0] CMD_WRITE_DISABLE    = 8'h04;
  localparam logic [7:0] CMD_CLEAR_STATUS_A   = 8'h30;
  localparam logic [7:0] CMD_CLEAR_STATUS_B   = 8'h82;
  localparam logic [7:0] CMD_SUSPEND_A        = 8'h85;
  localparam logic [7:0] CMD_SUSPEND_B        = 8'h75;
  localparam logic [7:0] CMD_SUSPEND_C        = 8'hb0;

  // field positions inside status register one
  localparam int SR_BUSY_POS  = 0;
  localparam int SR_WEL_POS   = 1;
  localparam int SR_BP_LO     = 2;
  localparam int SR_BP_HI     = 4;
  localparam int SR_EERR_POS  = 5;
  localparam int SR_PERR_POS  = 6;
  localparam int SR_STATUS_WRITE_DISABLE_POS  = 7;

  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] BP_CLEAR     = 3'h0;

  typedef enum logic [1:0] {
    FSOV_ST_IDLE  = 2'b00,
    FSOV_ST_BUSY  = 2'b01,
    FSOV_ST_ERROR = 2'b10
  } fsov_state_t;

  typedef enum logic [1:0] {
    FSOV_OP_PROGRAM = 2'b00,
    FSOV_OP_ERASE   = 2'b01,
    FSOV_OP_BULK    = 2'b10,
    FSOV_OP_REGWR   = 2'b11
  } fsov_op_kind_t;

  // command as handed over from the link side
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] data;
    logic       targets_status_one;
  } fsov_cmd_t;

  // request to the embedded-operation engine
  typedef struct packed {
    logic          start;
    logic          suspend;
    logic          abort;
    fsov_op_kind_t kind;
  } fsov_op_t;

endpackage : fsov_pkg
`default_nettype wire

// file: logic/fsov_status_one.sv
// volatile status register one with command gating and link-clock crossing
`timescale 1ns/100ps
`default_nettype none
module fsov_status_one #(
  parameter logic [7:0] CMD_PROGRAM      = 8'h02,
  parameter logic [7:0] CMD_SECTOR_ERASE = 8'hd8,
  parameter logic [7:0] CMD_BULK_ERASE   = 8'h60,
  parameter logic [7:0] CMD_SOFT_RESET   = 8'hf0
) (
  input  wire logic              sys_clk,
  input  wire logic              rst,
  input  wire logic              link_clk,
  input  wire logic              link_cmd_valid,
  input  wire fsov_pkg::fsov_cmd_t link_cmd,
  output logic                   link_cmd_ready,
  output logic [7:0]             link_status,
  input  wire logic              write_protect_n,
  input  wire logic              nv_status_write_disable,
  input  wire logic [2:0]        nv_protect_bits,
  input  wire logic              protect_source_select,
  input  wire logic              target_protected,
  input  wire logic              otp_locked,
  output fsov_pkg::fsov_op_t     op_req,
  input  wire logic              op_done,
  input  wire logic              op_fail,
  output logic                   nv_write_req,
  output logic [2:0]             nv_write_data,
  input  wire logic              nv_write_done,
  output logic [2:0]             active_protect_bits,
  output logic [7:0]             status_one_volatile
);
  import fsov_pkg::*;

  // ------------------------------------------------------------
  // crossing scheme
  // ------------------------------------------------------------
  // commands: link side flips a toggle and freezes the hold register;
  // system side sees the flip two flops later, acts on it for exactly
  // one cycle, then echoes the toggle back as the acknowledge
  // status: system side flips its own toggle with a frozen snapshot;
  // the link side copies the snapshot once the flip has crossed
  // neither word is read by the far domain while it can still change,
  // so no gray coding is needed for the multi-bit fields
  // limitation: one command in flight, so the host pays a full round
  // trip per command; acceptable for register and status traffic

  // ------------------------------------------------------------
  // link domain: reset synchroniser and command capture
  // ------------------------------------------------------------
  logic      link_rst_meta;
  logic      link_rst;
  logic      link_cmd_tgl;
  fsov_cmd_t link_cmd_hold;
  logic      cmd_ack_meta;
  logic      cmd_ack_link;
  logic      stat_tgl_meta;
  logic      stat_tgl_link;
  logic      stat_tgl_seen;

  logic      cmd_ack_tgl;
  logic      stat_tgl;
  logic [7:0] stat_hold;

  always_ff @(posedge link_clk) begin
    link_rst_meta <= rst;
    link_rst      <= link_rst_meta;
  end

  // the hold register stays put until the system side acknowledges
  assign link_cmd_ready = (link_cmd_tgl == cmd_ack_link);

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_cmd_tgl  <= 1'b0;
      link_cmd_hold <= '0;
    end else if (link_cmd_valid && link_cmd_ready) begin
      link_cmd_tgl  <= ~link_cmd_tgl;
      link_cmd_hold <= link_cmd;
    end
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      cmd_ack_meta  <= 1'b0;
      cmd_ack_link  <= 1'b0;
      stat_tgl_meta <= 1'b0;
      stat_tgl_link <= 1'b0;
      stat_tgl_seen <= 1'b0;
    end else begin
      cmd_ack_meta  <= cmd_ack_tgl;
      cmd_ack_link  <= cmd_ack_meta;
      stat_tgl_meta <= stat_tgl;
      stat_tgl_link <= stat_tgl_meta;
      stat_tgl_seen <= stat_tgl_link;
    end
  end

  // status snapshot for the read commands, held stable by the handshake
  wire stat_arrived = stat_tgl_link ^ stat_tgl_seen;

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      link_status <= STATUS_RESET;
    end else if (stat_arrived) begin
      link_status <= stat_hold;
    end
  end

  // ------------------------------------------------------------
  // system domain: synchronisers
  // ------------------------------------------------------------
  logic cmd_tgl_meta;
  logic cmd_tgl_sync;
  logic stat_ack_meta;
  logic stat_ack_sync;
  logic wp_n_meta;
  logic wp_n_sync;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_tgl_meta  <= 1'b0;
      cmd_tgl_sync  <= 1'b0;
      cmd_ack_tgl   <= 1'b0;
      stat_ack_meta <= 1'b0;
      stat_ack_sync <= 1'b0;
      wp_n_meta     <= 1'b1;
      wp_n_sync     <= 1'b1;
    end else begin
      cmd_tgl_meta  <= link_cmd_tgl;
      cmd_tgl_sync  <= cmd_tgl_meta;
      cmd_ack_tgl   <= cmd_tgl_sync;
      stat_ack_meta <= stat_tgl_seen;
      stat_ack_sync <= stat_ack_meta;
      wp_n_meta     <= write_protect_n;
      wp_n_sync     <= wp_n_meta;
    end
  end

  // ------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------
  wire       new_cmd = cmd_tgl_sync ^ cmd_ack_tgl;
  wire [7:0] code    = link_cmd_hold.code;

  wire is_read     = (code == CMD_READ_STATUS_ONE) || (code == CMD_READ_STATUS_TWO)
                     || (code == CMD_READ_ANY_REG);
  wire is_clear    = (code == CMD_CLEAR_STATUS_A) || (code == CMD_CLEAR_STATUS_B);
  wire is_suspend  = (code == CMD_SUSPEND_A) || (code == CMD_SUSPEND_B) || (code == CMD_SUSPEND_C);
  wire is_reset    = (code == CMD_SOFT_RESET);
  wire is_write_enable_cmd     = (code == CMD_WRITE_ENABLE);
  wire is_write_disable_cmd     = (code == CMD_WRITE_DISABLE);
  wire is_program  = (code == CMD_PROGRAM);
  wire is_erase    = (code == CMD_SECTOR_ERASE);
  wire is_bulk     = (code == CMD_BULK_ERASE);
  wire is_regwr_s1 = (code == CMD_WRITE_REGISTERS)
                     || ((code == CMD_WRITE_ANY_REG) && link_cmd_hold.targets_status_one);

  fsov_state_t   state;
  fsov_state_t   next_state;
  fsov_op_kind_t op_kind;
  logic          write_enable_latch;
  logic          p_err;
  logic          e_err;
  logic [2:0]    vol_bp;

  wire busy          = (state != FSOV_ST_IDLE);
  wire busy_allowed  = is_read || is_clear || is_suspend || is_reset;
  wire take          = new_cmd && (!busy || busy_allowed);
  wire idle_take     = take && (state == FSOV_ST_IDLE);
  wire hw_locked     = nv_status_write_disable && !wp_n_sync;
  wire regwr_ok      = idle_take && is_regwr_s1 && write_enable_latch && !hw_locked;
  wire program_ok    = idle_take && is_program && write_enable_latch;
  wire erase_ok      = idle_take && is_erase && write_enable_latch;
  wire bulk_ok       = idle_take && is_bulk && write_enable_latch && (active_protect_bits == BP_CLEAR);
  wire program_block = target_protected || otp_locked;
  wire in_array_op   = (state == FSOV_ST_BUSY) && (op_kind != FSOV_OP_REGWR);
  wire suspend_ok    = take && is_suspend && in_array_op
                       && (((code == CMD_SUSPEND_C) || (code == CMD_SUSPEND_A)) ?
                           (op_kind != FSOV_OP_PROGRAM) : (op_kind == FSOV_OP_PROGRAM)) ;
  wire reset_hit     = take && is_reset;
  wire clear_hit     = take && is_clear;
  wire nv_source     = !protect_source_select;
  wire busy_done     = (op_kind == FSOV_OP_REGWR) ? nv_write_done : op_done;

  // ------------------------------------------------------------
  // operation sequencer
  // ------------------------------------------------------------
  // idle:  accepts everything that the latch and protection allow
  // busy:  engine or nonvolatile store running, reads and a few
  //        control commands only
  // error: busy stays high until clear-status or soft reset; the
  //        engine is already stopped, so nothing is aborted here
  // a protected target never starts the engine; the error state is
  // entered directly so the flag and busy rise in the same edge
  always_comb begin
    next_state = state;
    case (state)
      FSOV_ST_IDLE: begin
        if (program_ok) begin
          next_state = program_block ? FSOV_ST_ERROR : FSOV_ST_BUSY;
        end else if (erase_ok) begin
          next_state = target_protected ? FSOV_ST_ERROR : FSOV_ST_BUSY;
        end else if (bulk_ok || (regwr_ok && nv_source)) begin
          next_state = FSOV_ST_BUSY;
        end
      end
      FSOV_ST_BUSY: begin
        if (reset_hit) begin
          next_state = FSOV_ST_IDLE;
        end else if (busy_done) begin
          next_state = (op_fail && op_kind != FSOV_OP_REGWR) ? FSOV_ST_ERROR : FSOV_ST_IDLE;
        end
      end
      FSOV_ST_ERROR: begin
        if (clear_hit || reset_hit) begin
          next_state = FSOV_ST_IDLE;
        end
      end
      default: next_state = FSOV_ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state   <= FSOV_ST_IDLE;
      op_kind <= FSOV_OP_PROGRAM;
    end else begin
      state <= next_state;
      if (program_ok) begin
        op_kind <= FSOV_OP_PROGRAM;
      end else if (erase_ok) begin
        op_kind <= FSOV_OP_ERASE;
      end else if (bulk_ok) begin
        op_kind <= FSOV_OP_BULK;
      end else if (regwr_ok && nv_source) begin
        op_kind <= FSOV_OP_REGWR;
      end
    end
  end

  // ------------------------------------------------------------
  // status bits
  // ------------------------------------------------------------
  // a failure is latched in the same edge that enters the error state, so
  // the flag is visible while busy is still high
  wire fail_end   = (state == FSOV_ST_BUSY) && op_done && op_fail && (op_kind != FSOV_OP_REGWR);
  wire set_p_err  = (program_ok && program_block)
                    || (fail_end && op_kind == FSOV_OP_PROGRAM);
  // whole-array erase only flags a real failure reported by the array,
  // not protected sectors skipped on the way
  wire set_e_err  = (erase_ok && target_protected)
                    || (fail_end && op_kind != FSOV_OP_PROGRAM);
  wire ok_end     = (state == FSOV_ST_BUSY) && busy_done && !(op_fail && op_kind != FSOV_OP_REGWR);
  wire vol_write  = regwr_ok && !nv_source;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      p_err <= 1'b0;
      e_err <= 1'b0;
    end else begin
      // set wins over clear; register writes never reach these
      p_err <= set_p_err || (p_err && !(clear_hit || reset_hit));
      e_err <= set_e_err || (e_err && !(clear_hit || reset_hit));
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      write_enable_latch <= 1'b0;
    end else if (reset_hit) begin
      write_enable_latch <= 1'b0;
    end else if (ok_end || vol_write) begin
      write_enable_latch <= 1'b0;
    end else if (idle_take && is_write_enable_cmd) begin
      write_enable_latch <= 1'b1;
    end else if (idle_take && is_write_disable_cmd) begin
      write_enable_latch <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      vol_bp <= BP_CLEAR;
    end else if (nv_source) begin
      vol_bp <= nv_protect_bits;
    end else if (vol_write) begin
      vol_bp <= link_cmd_hold.data[SR_BP_HI:SR_BP_LO];
    end
  end

  assign active_protect_bits = nv_source ? nv_protect_bits : vol_bp;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      nv_write_req  <= 1'b0;
      nv_write_data <= BP_CLEAR;
    end else begin
      nv_write_req <= regwr_ok && nv_source;
      if (regwr_ok && nv_source) begin
        nv_write_data <= link_cmd_hold.data[SR_BP_HI:SR_BP_LO];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      op_req <= '0;
    end else begin
      op_req.start   <= (program_ok && !program_block) || (erase_ok && !target_protected) || bulk_ok;
      op_req.suspend <= suspend_ok;
      op_req.abort   <= reset_hit && (state == FSOV_ST_BUSY);
      if (program_ok) begin
        op_req.kind <= FSOV_OP_PROGRAM;
      end else if (erase_ok) begin
        op_req.kind <= FSOV_OP_ERASE;
      end else if (bulk_ok) begin
        op_req.kind <= FSOV_OP_BULK;
      end
    end
  end

  wire [7:0] status_now = {nv_status_write_disable, p_err, e_err, vol_bp, write_enable_latch, busy};

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      status_one_volatile <= STATUS_RESET;
    end else begin
      status_one_volatile <= status_now;
    end
  end

  // ------------------------------------------------------------
  // status publish toward the link side
  // ------------------------------------------------------------
  // one snapshot in flight at a time; the link side may lag a few
  // link clocks behind a fast-changing status
  wire pub_free = (stat_tgl == stat_ack_sync);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_tgl  <= 1'b0;
      stat_hold <= STATUS_RESET;
    end else if (pub_free && (stat_hold != status_one_volatile)) begin
      stat_tgl  <= ~stat_tgl;
      stat_hold <= status_one_volatile;
    end
  end

endmodule : fsov_status_one
`default_nettype wire

// file: testbench/fsov_status_one_monitor.sv
// port checker for the volatile status-one register block
`timescale 1ns/100ps
`default_nettype none
module fsov_status_one_monitor (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire logic               nv_status_write_disable,
  input  wire logic [2:0]         nv_protect_bits,
  input  wire logic               protect_source_select,
  input  wire fsov_pkg::fsov_op_t op_req,
  input  wire logic               op_done,
  input  wire logic               op_fail,
  input  wire logic               nv_write_req,
  input  wire logic [2:0]         active_protect_bits,
  input  wire logic [7:0]         status_one_volatile
);
  import fsov_pkg::*;
  // ----------------------------------------
  // relations
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic busy    = status_one_volatile[SR_BUSY_POS];
  wire logic write_enable_latch     = status_one_volatile[SR_WEL_POS];
  wire logic err_any = status_one_volatile[SR_PERR_POS] | status_one_volatile[SR_EERR_POS];
  wire logic status_write_disable    = status_one_volatile[SR_STATUS_WRITE_DISABLE_POS];
  sequence s_fail_end;
    op_done && op_fail;
  endsequence
  sequence s_good_end;
    op_done && !op_fail;
  endsequence
  sequence s_error_held;
    err_any && busy;
  endsequence
  reset_clear_a: assert property (disable iff (1'b0)
    rst |=> status_one_volatile == STATUS_RESET) else $error("status not cleared by reset");
  mirror_follow_a: assert property (
    (status_write_disable != nv_status_write_disable) |-> ##[1:4] (status_write_disable == nv_status_write_disable)) else $error("status_write_disable copy lags");
  start_gated_a: assert property (
    op_req.start |-> ##[0:2] (busy && write_enable_latch)) else $error("start without latch or busy");
  start_pulse_a: assert property (
    op_req.start |=> !op_req.start) else $error("start longer than one cycle");
  fail_error_a: assert property (
    s_fail_end |-> ##[1:3] s_error_held) else $error("failure not flagged while busy");
  error_busy_a: assert property (
    err_any |-> busy) else $error("error flag without busy");
  error_blocks_a: assert property (
    err_any |-> !op_req.start) else $error("operation started in error");
  good_end_a: assert property (
    s_good_end |-> ##[1:3] (!write_enable_latch && !busy)) else $error("latch or busy kept after success");
  nv_pulse_a: assert property (
    nv_write_req |=> !nv_write_req) else $error("nv write request too long");
  src_nv_a: assert property (
    !protect_source_select |-> active_protect_bits == nv_protect_bits) else $error("wrong protect source");
  vol_copy_a: assert property (
    $past(!protect_source_select, 2) |-> status_one_volatile[SR_BP_HI:SR_BP_LO] == $past(nv_protect_bits, 2))
    else $error("volatile protect copy stale");
  abort_idle_a: assert property (
    op_req.abort |=> (!busy && !write_enable_latch)) else $error("soft reset left busy or latch");
endmodule : fsov_status_one_monitor
bind fsov_status_one fsov_status_one_monitor i_fsov_status_one_monitor (
  .sys_clk(sys_clk), .rst(rst), .nv_status_write_disable(nv_status_write_disable),
  .nv_protect_bits(nv_protect_bits), .protect_source_select(protect_source_select), .op_req(op_req),
  .op_done(op_done), .op_fail(op_fail), .nv_write_req(nv_write_req),
  .active_protect_bits(active_protect_bits), .status_one_volatile(status_one_volatile));
`default_nettype wire

// file: testbench/fsov_engine_model.sv
// behavioural operation engine and nonvolatile protect store
`timescale 1ns/100ps
`default_nettype none
module fsov_engine_model (
  input  wire logic               sys_clk,
  input  wire logic               rst,
  input  wire fsov_pkg::fsov_op_t op_req,
  input  wire logic               fail_next,
  input  wire logic               slow,
  input  wire logic               nv_write_req,
  input  wire logic [2:0]         nv_write_data,
  output logic                    op_done,
  output logic                    op_fail,
  output logic                    nv_write_done,
  output logic [2:0]              nv_protect_bits
);
  import fsov_pkg::*;
  int         run;
  int         nv_run;
  logic [2:0] nv_pend;
  // no resume path exists, so a suspend just ends the run early
  always_ff @(posedge sys_clk) begin
    op_done       <= 1'b0;
    op_fail       <= 1'b0;
    nv_write_done <= 1'b0;
    if (rst) begin
      run             <= 0;
      nv_run          <= 0;
      nv_pend         <= BP_CLEAR;
      nv_protect_bits <= BP_CLEAR;
    end else begin
      if (op_req.start) run <= slow ? 600 : 3;
      else if (op_req.abort) run <= 0;
      else if (op_req.suspend && run > 3) run <= 3;
      else if (run != 0) run <= run - 1;
      if (run == 1 && !op_req.abort) begin
        op_done <= 1'b1;
        op_fail <= fail_next; // skipped protected sectors never reported
      end
      if (nv_write_req) begin
        nv_run  <= 4;
        nv_pend <= nv_write_data;
      end else if (nv_run != 0) nv_run <= nv_run - 1;
      // store takes the new bits only when done
      if (nv_run == 1) begin
        nv_write_done   <= 1'b1;
        nv_protect_bits <= nv_pend;
      end
    end
  end
endmodule : fsov_engine_model
`default_nettype wire

// file: testbench/fsov_status_one_tb.sv
// self-checking bench of the volatile status-one register block
`timescale 1ns/100ps
`default_nettype none
module fsov_status_one_tb;
  import fsov_pkg::*;
  logic       sys_clk = 1'b0, link_clk = 1'b0, rst = 1'b1, link_cmd_valid = 1'b0;
  fsov_cmd_t  link_cmd = '0;
  logic       write_protect_n = 1'b1, nv_sw = 1'b0, src_sel = 1'b0, target_protected = 1'b0;
  logic       otp_locked = 1'b0, fail_next = 1'b0, slow = 1'b0;
  logic       link_cmd_ready, op_done, op_fail, nv_write_req, nv_write_done;
  logic [7:0] link_status, sov;
  logic [2:0] nv_write_data, nv_bits, act_bits;
  fsov_op_t   op_req;
  int         errors = 0, samples_checked = 0, cyc = 0, starts = 0, susp = 0, nvw = 0;
  // ----------------------------------------
  // clocks, design and far side
  // ----------------------------------------
  always #2.5 sys_clk = ~sys_clk;
  initial #1.3 forever #40 link_clk = ~link_clk;
  fsov_status_one i_fsov_status_one (.sys_clk(sys_clk), .rst(rst), .link_clk(link_clk),
    .link_cmd_valid(link_cmd_valid), .link_cmd(link_cmd), .link_cmd_ready(link_cmd_ready),
    .link_status(link_status), .write_protect_n(write_protect_n), .nv_status_write_disable(nv_sw),
    .nv_protect_bits(nv_bits), .protect_source_select(src_sel), .target_protected(target_protected),
    .otp_locked(otp_locked), .op_req(op_req), .op_done(op_done), .op_fail(op_fail),
    .nv_write_req(nv_write_req), .nv_write_data(nv_write_data), .nv_write_done(nv_write_done),
    .active_protect_bits(act_bits), .status_one_volatile(sov));
  fsov_engine_model i_fsov_engine_model (.sys_clk(sys_clk), .rst(rst), .op_req(op_req),
    .fail_next(fail_next), .slow(slow), .nv_write_req(nv_write_req), .nv_write_data(nv_write_data),
    .op_done(op_done), .op_fail(op_fail), .nv_write_done(nv_write_done), .nv_protect_bits(nv_bits));
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (op_req.start === 1'b1) starts <= starts + 1;
    if (op_req.suspend === 1'b1) susp <= susp + 1;
    if (nv_write_req === 1'b1) nvw <= nvw + 1;
    if (cyc == 20000) begin
      errors = errors + 1;
      end_sim();
    end
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk8
  // ready is checked before the edge, so no race with its own fall
  task automatic send(input logic [7:0] code, input logic [7:0] data);
    int n;
    n = 0;
    @(negedge link_clk);
    link_cmd_valid = 1'b1;
    link_cmd = {code, data, 1'b1};
    while (link_cmd_ready !== 1'b1 && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    @(negedge link_clk);
    link_cmd_valid = 1'b0;
    n = 0;
    while (link_cmd_ready !== 1'b1 && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    chk8({7'h0, link_cmd_ready}, 8'h01);
    repeat (6) @(negedge sys_clk);
  endtask : send
  task automatic step(input logic [7:0] code, input logic [7:0] data, input logic [7:0] exp);
    send(code, data);
    chk8(sov, exp);
  endtask : step
  task automatic end_sim;
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_sim
  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    repeat (8) @(negedge link_clk);
    rst = 1'b0;
    repeat (4) @(negedge link_clk);
    chk8(sov, STATUS_RESET);
    chk8(link_status, 8'h00);
    step(8'h02, 8'h00, 8'h00);
    chk8(starts[7:0], 8'h00);
    step(CMD_WRITE_ENABLE, 8'h00, 8'h02);
    step(CMD_WRITE_DISABLE, 8'h00, 8'h00);
    slow = 1'b1;
    step(CMD_WRITE_ENABLE, 8'h00, 8'h02);
    step(8'h02, 8'h00, 8'h03);
    step(CMD_WRITE_DISABLE, 8'h00, 8'h03);
    send(CMD_READ_STATUS_ONE, 8'h00);
    repeat (4) @(negedge link_clk);
    chk8(link_status, 8'h03);
    step(CMD_SUSPEND_A, 8'h00, 8'h03);
    chk8(susp[7:0], 8'h00);
    send(CMD_SUSPEND_B, 8'h00);
    chk8(susp[7:0], 8'h01);
    while (sov[0] !== 1'b0 && cyc < 19000) @(negedge sys_clk);
    chk8(sov, 8'h00);
    step(CMD_WRITE_ENABLE, 8'h00, 8'h02);
    step(8'h02, 8'h00, 8'h03);
    step(8'hf0, 8'h00, 8'h00);
    slow = 1'b0;
    fail_next = 1'b1;
    step(CMD_WRITE_ENABLE, 8'h00, 8'h02);
    step(8'h02, 8'h00, 8'h43);
    step(8'hd8, 8'h00, 8'h43);
    chk8(starts[7:0], 8'h03);
    step(CMD_CLEAR_STATUS_A, 8'h00, 8'h02);
    step(CMD_WRITE_DISABLE, 8'h00, 8'h00);
    fail_next = 1'b0;
    target_protected = 1'b1;
    step(CMD_WRITE_ENABLE, 8'h00, 8'h02);
    step(8'hd8, 8'h00, 8'h23);
    step(CMD_CLEAR_STATUS_B, 8'h00, 8'h02);
    target_protected = 1'b0;
    otp_locked = 1'b1;
    step(8'h02, 8'h00, 8'h43);
    step(8'hf0, 8'h00, 8'h00);
    otp_locked = 1'b0;
    chk8(starts[7:0], 8'h03);
    step(CMD_WRITE_ENABLE, 8'h00, 8'h02);
    step(CMD_WRITE_REGISTERS, 8'h7c, 8'h1c);
    chk8({5'h0, act_bits}, 8'h07);
    step(CMD_WRITE_ENABLE, 8'h00, 8'h1e);
    step(8'h60, 8'h00, 8'h1e);
    step(CMD_WRITE_ANY_REG, 8'h00, 8'h00);
    step(CMD_WRITE_ENABLE, 8'h00, 8'h02);
    step(8'h60, 8'h00, 8'h00);
    chk8(starts[7:0], 8'h04);
    src_sel = 1'b1;
    step(CMD_WRITE_ENABLE, 8'h00, 8'h02);
    step(CMD_WRITE_REGISTERS, 8'h08, 8'h08);
    chk8(nvw[7:0], 8'h02);
    chk8({5'h0, act_bits}, 8'h02);
    nv_sw = 1'b1;
    repeat (6) @(negedge sys_clk);
    chk8(sov, 8'h88);
    write_protect_n = 1'b0;
    step(CMD_WRITE_ENABLE, 8'h00, 8'h8a);
    step(CMD_WRITE_REGISTERS, 8'h00, 8'h8a);
    write_protect_n = 1'b1;
    step(CMD_WRITE_REGISTERS, 8'h00, 8'h80);
    end_sim();
  end
endmodule : fsov_status_one_tb
`default_nettype wire
